//--- sbst_consts.svh
// Constant definitions for the boundary-scan test access port
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH
// ****************************************
// Instruction codes and widths
// ****************************************
`define SBST_IR_W         3
`define SBST_IR_EXTEST    3'h0
`define SBST_IR_IDCODE    3'h1
`define SBST_IR_SAMPLEZ   3'h2
`define SBST_IR_SAMPLE    3'h4
`define SBST_IR_BYPASS    3'h7
`define SBST_IR_CAPTURE   3'h1
`define SBST_ID_W         32
`define SBST_BSR_W        8
`define SBST_RST_HITS     3'h5
`endif

//--- sbst_ctl_model.sv
// Model of the external scan controller driving the test pins
`timescale 1ns/100ps
module sbst_ctl_model (
  input  wire logic i_clk,
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  // ****************
  // Pin driving
  // ****************
  initial begin
    o_tck = 1'b0; // Held low until the first frame
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // One 900 ns test clock; data out is read late so it has settled
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clk);
    o_tck <= 1'b0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_clk);
    o_tck <= 1'b1;
    repeat (4) @(posedge i_clk);
    tdo = i_tdo;
  endtask : step
endmodule : sbst_ctl_model

//--- sbst_pin_sync.sv
// Pin synchroniser and test-clock edge finder
`timescale 1ns/100ps
module sbst_pin_sync (
  input  wire logic I_CLOCK,
  input  wire logic I_SRST,
  input  wire logic i_tck,
  input  wire logic i_tms,
  input  wire logic i_tdi,
  sbst_sync_if.src  sync
);
  logic [1:0] tck_s_r;
  logic [1:0] tms_s_r;
  logic [1:0] tdi_s_r;
  logic       tck_d_r;
  // ****************************************
  // Two-stage synchronisers; only stage two is read
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      tck_s_r <= 2'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h3;
      tck_d_r <= 1'b0;
    end else begin
      tck_s_r <= {tck_s_r[0], i_tck};
      tms_s_r <= {tms_s_r[0], i_tms};
      tdi_s_r <= {tdi_s_r[0], i_tdi};
      tck_d_r <= tck_s_r[1];
    end
  end
  // Edge detection works off the second stage
  assign sync.tck_rise = tck_s_r[1] & ~tck_d_r;
  assign sync.tck_fall = ~tck_s_r[1] & tck_d_r;
  assign sync.tms      = tms_s_r[1];
  assign sync.tdi      = tdi_s_r[1];
endmodule : sbst_pin_sync

//--- sbst_pkg.sv
// Types shared by the boundary-scan test port
package sbst_pkg;
  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_t;
endpackage : sbst_pkg

//--- sbst_sync_if.sv
// Interface carrying the synchronised pin levels and test-clock edges
`timescale 1ns/100ps
interface sbst_sync_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  modport src (output tck_rise, output tck_fall, output tms, output tdi);
  modport dst (input tck_rise, input tck_fall, input tms, input tdi);
endinterface : sbst_sync_if

//--- sbst_tap.sv
// Boundary-scan test access port top module
`timescale 1ns/100ps
`include "sbst_consts.svh"
// Overview of operation
// - Inputs sampled on test-clock rise, serial output changes on test-clock fall.
// - Undriven mode-select reads as one; pull-up modelled by caller.
// - Only the register selected by current instruction sits between data pins.
// - Serial data enters the selected register at its MSB.
// - Serial output shows the selected register's LSB.
// - Data output enabled only in shift states, else high-impedance.
// - Controller follows sixteen-state diagram on each rising test-clock edge.
// - Power-up reset enters reset state and leaves memory undisturbed.
// - Holds controller, instruction, boundary, bypass and identification registers.
// - Test clock drives only test logic, independent of memory clock.
// - Five rising edges with mode-select high reset the test logic.
// - Three-bit instruction register loads identification code on reset.
// - Instruction capture loads binary 01 into two lowest bits.
// - One-bit bypass register cleared to zero on capture.
module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [31:0] ID_WORD = 32'h1234_5679, // Arbitrary identification value
  parameter int          BSR_W   = `SBST_BSR_W
) (
  input  wire logic             I_CLOCK,
  input  wire logic             I_SRST,
  input  wire logic             I_TCK,
  input  wire logic             I_TMS,
  input  wire logic             I_TDI,
  input  wire logic [BSR_W-1:0] I_PINS,
  output logic                  O_TDO,
  output logic                  O_TDO_OE,
  output logic [BSR_W-1:0]      O_PINS,
  output logic                  O_PINS_OE,
  output logic                  O_OUTBUS_HIZ
);
  // ****************************************
  // Elaboration check: the bus-drive cell needs at least one data cell below it
  // ****************************************
  if (BSR_W < 2) begin : g_bad_width
    $error("BSR_W must be at least 2");
  end
  sbst_sync_if sync ();
  // ****************************************
  // Pin synchroniser, runs on the single system clock
  // ****************************************
  sbst_pin_sync u_sync (
    .I_CLOCK (I_CLOCK),
    .I_SRST  (I_SRST),
    .i_tck   (I_TCK),
    .i_tms   (I_TMS),
    .i_tdi   (I_TDI),
    .sync    (sync.src)
  );
  sbst_state_t                state_r;
  sbst_state_t                state_nxt;
  logic [`SBST_IR_W-1:0]      ir_sh_r;
  logic [`SBST_IR_W-1:0]      ir_r;
  logic                       byp_r;
  logic [`SBST_ID_W-1:0]      id_r;
  logic [BSR_W-1:0]           bsr_r;
  logic [BSR_W-1:0]           bsr_upd_r;
  logic [2:0]                 tms_hits_r;
  logic                       tdo_r;
  logic                       tdo_oe_r;
  logic [BSR_W-1:0]           pins_s1_r;
  logic [BSR_W-1:0]           pins_s2_r;
  // ****************************************
  // Boundary pin synchroniser
  // ****************************************
  // The pins move with the memory's own clock, so two stages guard the
  // capture against a bit caught mid-transition; costs two cycles of latency
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
    end else begin
      pins_s1_r <= I_PINS;
      pins_s2_r <= pins_s1_r; // Only stage two feeds the capture
    end
  end
  // ****************************************
  // Next-state decode of the sixteen-state diagram
  // ****************************************
  wire tms = sync.tms;
  always_comb begin
    case (state_r)
      ST_RESET:  state_nxt = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_nxt = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: state_nxt = tms ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_nxt = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: state_nxt = tms ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
      default:   state_nxt = ST_RESET;
    endcase
  end
  // ****************************************
  // Instruction decode and register selection
  // ****************************************
  wire sel_id   = (ir_r == `SBST_IR_IDCODE);
  wire sel_byp  = (ir_r == `SBST_IR_BYPASS) | (ir_r[2:1] == 2'h1 & ir_r[0]) |
                  (ir_r == 3'h5) | (ir_r == 3'h6); // Reserved codes act as bypass
  wire sel_bsr  = ~sel_id & ~sel_byp;
  wire rise     = sync.tck_rise;
  wire fall     = sync.tck_fall;
  wire in_shdr  = (state_r == ST_SHF_DR);
  wire in_shir  = (state_r == ST_SHF_IR);
  wire dr_bit   = sel_id ? id_r[0] : (sel_byp ? byp_r : bsr_r[0]);
  wire tdo_nxt  = in_shir ? ir_sh_r[0] : dr_bit;
  // ****************************************
  // State strobes; each is acted on only at a detected test-clock rise
  // ****************************************
  wire       in_reset  = (state_r == ST_RESET);
  wire       cap_ir    = (state_r == ST_CAP_IR);
  wire       cap_dr    = (state_r == ST_CAP_DR);
  wire       upd_ir    = (state_r == ST_UPD_IR);
  wire       upd_dr    = (state_r == ST_UPD_DR) & sel_bsr; // Only the boundary register has an update stage
  // Run of mode-select highs; saturates so a long run cannot wrap back to zero
  wire       hits_full = (tms_hits_r == `SBST_RST_HITS);
  wire [2:0] hits_nxt  = tms ? (hits_full ? tms_hits_r : tms_hits_r + 3'h1) : 3'h0;
  // The diagram already reaches reset by the fifth high; this forces it from any state
  wire       hit_last  = tms & (tms_hits_r == `SBST_RST_HITS - 3'h1);
  // ****************************************
  // Controller state; a five-edge mode-select run also forces reset
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      state_r    <= ST_RESET;
      tms_hits_r <= 3'h0;
    end else if (rise) begin
      tms_hits_r <= hits_nxt;
      // A forced reset wins over the diagram's own next state
      state_r    <= hit_last ? ST_RESET : state_nxt;
    end
  end
  // ****************************************
  // Instruction register: capture 01, shift in at MSB, update on exit
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      ir_sh_r <= `SBST_IR_IDCODE;
      ir_r    <= `SBST_IR_IDCODE;
    end else if (rise) begin
      if (in_reset) begin
        ir_r <= `SBST_IR_IDCODE;
      end
      // Fixed low pattern lets a tester check the serial path before shifting
      if (cap_ir) begin
        ir_sh_r <= {ir_sh_r[2], 2'h1};
      end else if (in_shir) begin
        ir_sh_r <= {sync.tdi, ir_sh_r[2:1]};
      end
      if (upd_ir) begin
        ir_r <= ir_sh_r;
      end
    end
  end
  // ****************************************
  // Data registers; only the selected one captures and shifts
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      byp_r     <= 1'b0;
      id_r      <= ID_WORD;
      bsr_r     <= '0;
      bsr_upd_r <= {1'b1, {(BSR_W-1){1'b0}}}; // Bus-drive bit preset high
    end else if (rise) begin
      if (in_reset) begin
        bsr_upd_r[BSR_W-1] <= 1'b1;
      end
      if (cap_dr) begin
        if (sel_byp) byp_r <= 1'b0;
        if (sel_id) id_r <= ID_WORD;
        if (sel_bsr) bsr_r <= pins_s2_r;
      end else if (in_shdr) begin
        if (sel_byp) byp_r <= sync.tdi;
        if (sel_id) id_r <= {sync.tdi, id_r[`SBST_ID_W-1:1]};
        if (sel_bsr) bsr_r <= {sync.tdi, bsr_r[BSR_W-1:1]};
      end
      if (upd_dr) begin
        bsr_upd_r <= bsr_r;
      end
    end
  end
  // ****************************************
  // Serial output, moved only on test-clock fall
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (fall) begin
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= in_shdr | in_shir;
    end
  end
  // ****************************************
  // Pin outputs
  // ****************************************
  // Boundary outputs only drive under external test; SAMPLEZ floats the output bus, other codes leave memory alone
  wire extest = (ir_r == `SBST_IR_EXTEST);
  assign O_TDO        = tdo_r;
  assign O_TDO_OE     = tdo_oe_r;
  assign O_PINS       = bsr_upd_r;
  assign O_PINS_OE    = extest & bsr_upd_r[BSR_W-1];
  assign O_OUTBUS_HIZ = (ir_r == `SBST_IR_SAMPLEZ) | (extest & ~bsr_upd_r[BSR_W-1]);
endmodule : sbst_tap

//--- sbst_tap_chk.sv
// Concurrent checks on the test port pins
`timescale 1ns/100ps
module sbst_tap_chk #(
  parameter int BSR_W = 8
) (
  input wire logic             I_CLOCK,
  input wire logic             I_SRST,
  input wire logic             I_TCK,
  input wire logic             I_TMS,
  input wire logic             I_TDI,
  input wire logic [BSR_W-1:0] I_PINS,
  input wire logic             O_TDO,
  input wire logic             O_TDO_OE,
  input wire logic [BSR_W-1:0] O_PINS,
  input wire logic             O_PINS_OE,
  input wire logic             O_OUTBUS_HIZ
);
  // ****************
  // Edge tracking
  // ****************
  logic       tck_r, tms_rise_r, last_tms_r;
  logic [3:0] age_r, quiet_r;
  logic [2:0] hits_r;
  wire        fall = tck_r & ~I_TCK;
  wire        rise = ~tck_r & I_TCK;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SRST);
  // Saturating counts so long idle spells cannot wrap into a false window
  always_ff @(posedge I_CLOCK) begin
    tck_r      <= I_TCK;
    age_r      <= (I_SRST | fall) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
    quiet_r    <= (I_SRST | fall | rise) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
    hits_r     <= (I_SRST | (rise & ~I_TMS)) ? 3'h0 : hits_r + {2'h0, rise && hits_r != 3'h5};
    tms_rise_r <= I_SRST | (rise ? I_TMS : tms_rise_r);
    last_tms_r <= I_SRST | (fall ? tms_rise_r : last_tms_r);
  end
  // ****************
  // Assertions
  // ****************
  a_tdo_fall_edge: assert property ($changed(O_TDO) |-> age_r inside {[1:6]})
    else $error("data out moved away from a clock fall");
  a_oe_fall_edge: assert property ($changed(O_TDO_OE) |-> age_r inside {[1:6]})
    else $error("driver enable moved away from a clock fall");
  a_oe_off_exit: assert property (age_r == 4'h7 && last_tms_r |-> !O_TDO_OE)
    else $error("driver on outside a shift state");
  a_oe_rise_shift: assert property ($rose(O_TDO_OE) |-> !last_tms_r)
    else $error("driver enabled after a mode-select high edge");
  a_rst_quiet: assert property ($fell(I_SRST) |-> !O_TDO_OE && !O_TDO && !O_PINS_OE && !O_OUTBUS_HIZ)
    else $error("outputs not quiet after reset");
  a_five_hit_reset: assert property (hits_r == 3'h5 |-> ##[0:8] !O_PINS_OE && !O_OUTBUS_HIZ)
    else $error("five mode-select highs left a bus instruction");
  a_bus_cell_set: assert property (hits_r == 3'h5 |-> ##[0:8] O_PINS[BSR_W-1])
    else $error("bus drive cell not preset in reset state");
  a_tck_idle_hold: assert property (quiet_r == 4'hf |-> $stable(O_TDO) && $stable(O_TDO_OE) && $stable(O_PINS))
    else $error("outputs moved with the test clock still");
  c_oe_on: cover property ($rose(O_TDO_OE));
  c_five_hit: cover property (hits_r == 3'h5);
  c_bus_drive: cover property (O_PINS_OE);
endmodule : sbst_tap_chk
bind sbst_tap sbst_tap_chk #(.BSR_W(BSR_W)) u_chk (
  .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_TCK(I_TCK), .I_TMS(I_TMS), .I_TDI(I_TDI), .I_PINS(I_PINS),
  .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .O_PINS(O_PINS), .O_PINS_OE(O_PINS_OE), .O_OUTBUS_HIZ(O_OUTBUS_HIZ));

//--- sbst_tap_tb.sv
// Testbench for the boundary-scan test port
`timescale 1ns/100ps
module sbst_tap_tb;
  // ****************
  // Wiring
  // ****************
  localparam logic [31:0] ID = 32'h0bad_f00d; // Arbitrary identification value
  localparam int          BW = 8;
  logic          clk, srst, tck, tms, tdi, tdo_q, oe, poe, hiz;
  logic [BW-1:0] pins_i, pins_o;
  logic [39:0]   got;
  logic [7:0]    r;
  logic [2:0]    bp [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
  int            error_cnt, num_checks, cyc;
  wire           tdo_w = oe ? tdo_q : ~tdo_q; // A released line shows no stale level
  sbst_tap #(.ID_WORD(ID), .BSR_W(BW)) dut (
    .I_CLOCK(clk), .I_SRST(srst), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .I_PINS(pins_i),
    .O_TDO(tdo_q), .O_TDO_OE(oe), .O_PINS(pins_o), .O_PINS_OE(poe), .O_OUTBUS_HIZ(hiz));
  sbst_ctl_model u_ctl (.i_clk(clk), .i_tdo(tdo_w), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle ceiling, well above the roughly 2200 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic cmp(input logic [39:0] g, input logic [39:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic scan(input logic [39:0] m, input logic [39:0] d, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      u_ctl.step(m[i], d[i], b);
      got[i] = b;
    end
  endtask : scan
  // Load an instruction from idle; the captured pattern leaves first
  task automatic ir(input logic [2:0] code);
    scan(40'h0_0000_00c3, {33'h0, code, 4'h0}, 9);
    cmp(40'(got[5:4]), 40'h1);
  endtask : ir
  // Shift n bits through the selected data register, idle to idle
  task automatic dr(input int n, input logic [39:0] d);
    scan(40'h1 | (40'h3 << (n + 2)), d << 3, n + 5);
    got = (got >> 3) & ((40'h1 << n) - 40'h1);
  endtask : dr
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ****************
  // Scenarios
  // ****************
  initial begin
    srst   = 1'b1;
    pins_i = '0;
    void'($urandom(8));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (20) @(posedge clk);
    cmp({38'h0, oe, pins_o[BW-1]}, 40'h1);
    u_ctl.step(1'b0, 1'b1, r[0]);
    dr(32, {8'h0, $urandom});
    cmp(got, {8'h0, ID});
    foreach (bp[k]) begin
      r = 8'($urandom);
      ir(bp[k]);
      dr(8, {32'h0, r});
      cmp(got, {32'h0, r[6:0], 1'b0});
    end
    // Bus drive cell both ways: capture, preload, then drive or float
    for (int k = 0; k < 2; k++) begin
      r = {k[0], 7'($urandom)};
      @(posedge clk);
      pins_i <= BW'($urandom);
      ir(3'h4);
      dr(BW, {32'h0, r});
      cmp(got, {32'h0, pins_i});
      cmp({32'h0, pins_o}, {32'h0, r});
      ir(3'h0);
      cmp({38'h0, poe, hiz}, {38'h0, r[7], ~r[7]});
    end
    ir(3'h2);
    cmp({38'h0, poe, hiz}, 40'h1);
    for (int k = 0; k < 5; k++) u_ctl.step(1'b1, 1'b0, r[0]);
    cmp({38'h0, poe, hiz}, 40'h0);
    u_ctl.step(1'b0, 1'b1, r[0]);
    dr(32, 40'h0);
    cmp(got, {8'h0, ID});
    end_sim();
  end
endmodule : sbst_tap_tb
